/* isp_core_model.sv */
// Behavioural core for the interrupt source block: takes requests, returns.
// Assumes requests are sampled on core_clk and srst resets it.
`timescale 1ns/1ps
module isp_core_model
	import isp_pkg::*;
#(
	parameter logic [PC_W-1:0] ENTRY_PC = 21'h00100,
	parameter logic [23:0]     CTX      = 24'h123456
)
(
	input  wire logic            core_clk,
	input  wire logic            srst,
	input  wire logic            irq_high,
	input  wire logic            irq_low,
	input  wire logic            ack_en,
	input  wire logic            ret_req,
	output logic                 core_irq_ack,
	output logic                 core_irq_return,
	output logic      [PC_W-1:0] core_ret_pc,
	output logic      [7:0]      core_working_reg,
	output logic      [7:0]      core_status_reg,
	output logic      [7:0]      core_bank_select_reg
);
	logic in_isr;

	// One entry per request; the handler stays in until told to return
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			core_irq_ack    <= 1'b0;
			core_irq_return <= 1'b0;
			in_isr          <= 1'b0;
		end
		else
		begin
			core_irq_ack    <= ack_en && !in_isr && !core_irq_ack && (irq_high || irq_low);
			core_irq_return <= ret_req && in_isr;
			in_isr          <= (in_isr || core_irq_ack) && !core_irq_return;
		end
	end

	// Context is valid only during entry; the inverse shows otherwise
	assign core_ret_pc          = core_irq_ack ? ENTRY_PC : ~ENTRY_PC;
	assign core_working_reg     = core_irq_ack ? CTX[23:16] : ~CTX[23:16];
	assign core_status_reg      = core_irq_ack ? CTX[15:8] : ~CTX[15:8];
	assign core_bank_select_reg = core_irq_ack ? CTX[7:0] : ~CTX[7:0];
endmodule

/* isp_irq_sources.sv */
// Interrupt sources, priority resolution and context saving, APB register slave.
// Assumes pins arrive asynchronously and core strobes are core_clk pulses.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module isp_irq_sources
	import isp_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [N_EXT-1:0]  ext_irq_pins,
	input  wire logic [N_PORT-1:0] port_pins,
	input  wire logic              timer_tick,
	input  wire logic [4:0]        cause_set,
	input  wire logic [4:0]        cause_clr,
	input  wire logic              core_sleep,
	input  wire logic              core_irq_ack,
	input  wire logic              core_irq_return,
	input  wire logic [PC_W-1:0]   core_ret_pc,
	input  wire logic [7:0]        core_working_reg,
	input  wire logic [7:0]        core_status_reg,
	input  wire logic [7:0]        core_bank_select_reg,
	output logic                   irq_high,
	output logic                   irq_low,
	output logic                   wake_req,
	output logic                   wake_branch,
	output logic      [PC_W-1:0]   ret_pc,
	output logic                   ret_pc_valid,
	output logic      [7:0]        fast_working_reg,
	output logic      [7:0]        fast_status_reg,
	output logic      [7:0]        fast_bank_select_reg
);
	function automatic logic isp_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		isp_hit = (a == off);
	endfunction

	logic [7:0]          reset_control_reg;
	logic [7:0]          irq_control_reg;
	logic [7:0]          irq_control_reg_second;
	logic [7:0]          irq_control_reg_third;
	logic [7:0]          tmr_low;
	logic [7:0]          tmr_high;
	logic [7:0]          tmr_cfg;
	logic [N_PORT-1:0]   port_dir;
	logic [N_PORT-1:0]   port_old;
	logic                stk_ovf;
	logic                stk_unf;
	logic [5:0]          stk_ptr;
	logic [6:0]          sync1;
	logic [6:0]          sync2;
	logic [6:0]          sync3;
	logic [6:0]          stable;
	logic [6:0]          agree;
	logic [6:0]          changed;
	logic [N_EXT-1:0]    ext_edge_select;
	logic [N_EXT-1:0]    ext_edge;
	logic [N_PORT-1:0]   port_mis;
	logic                wr_go;
	logic                rd_setup;
	logic                addr_ok;
	logic [7:0]          rd_val;
	logic [7:0]          wb;
	logic                tmr_inc;
	logic                wrap_low;
	logic                tmr_ovf;
	logic [N_SRC-1:0]    src_flag;
	logic [N_SRC-1:0]    src_en;
	logic [N_SRC-1:0]    src_prio;
	logic [N_SRC-1:0]    src_active;
	logic                priority_levels_enable;
	logic                next_high;
	logic                next_low;
	logic                push;
	logic                pop;

	assign wb = pwdata[7:0];
	assign wr_go = psel && penable && pready && pwrite && pstrb[0];
	assign rd_setup = psel && !penable && !pwrite;
	assign priority_levels_enable = reset_control_reg[RC_PRIO_EN];

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge core_clk)
	begin
		sync1 <= {port_pins, ext_irq_pins};
		sync2 <= sync1;
		sync3 <= sync2;
		// Track the settled level in reset so a pin held high gives no false edge
		if (srst)
			stable <= sync3;
		else
			stable <= (stable & ~agree) | (sync3 & agree);
	end

	assign agree = ~(sync2 ^ sync3);
	assign changed = agree & (sync3 ^ stable);
	assign ext_edge_select = {irq_control_reg_second[IC2_EDGE2],
		irq_control_reg_second[IC2_EDGE1], irq_control_reg_second[IC2_EDGE0]};

	genvar gi;
	generate
		for (gi = 0; gi < N_EXT; gi++)
		begin : g_edge
			assign ext_edge[gi] = changed[gi] && (sync3[gi] == ext_edge_select[gi]);
		end
	endgenerate

	assign port_mis = (stable[6:3] ^ port_old) & port_dir;

	// Register decode
	always_comb
	begin
		addr_ok = 1'b1;
		rd_val = 8'h00;
		if (isp_hit(paddr, OFF_RESET_CTRL))
			rd_val = reset_control_reg & RC_IMPL_MASK;
		else if (isp_hit(paddr, OFF_IRQ_CTRL))
			rd_val = irq_control_reg;
		else if (isp_hit(paddr, OFF_IRQ_CTRL2))
			rd_val = irq_control_reg_second;
		else if (isp_hit(paddr, OFF_IRQ_CTRL3))
			rd_val = irq_control_reg_third;
		else if (isp_hit(paddr, OFF_TMR_LOW))
			rd_val = tmr_low;
		else if (isp_hit(paddr, OFF_TMR_HIGH))
			rd_val = tmr_high;
		else if (isp_hit(paddr, OFF_TMR_CFG))
			rd_val = tmr_cfg;
		else if (isp_hit(paddr, OFF_PORT_VAL))
			rd_val = {stable[6:3], 4'h0};
		else if (isp_hit(paddr, OFF_PORT_DIR))
			rd_val = {port_dir, 4'h0};
		else if (isp_hit(paddr, OFF_CORE_STAT))
			rd_val = {3'h0, wake_req, stk_unf, stk_ovf, irq_low, irq_high};
		else
			addr_ok = 1'b0;
	end

	// Zero-wait APB: answer registered during the setup cycle
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			prdata <= rd_setup ? {24'h00_0000, rd_val} : 32'h0000_0000;
		end
	end

	// Port snapshot taken by a read of the port value
	always_ff @(posedge core_clk)
	begin
		if (srst)
			port_old <= 4'h0;
		else if (rd_setup && isp_hit(paddr, OFF_PORT_VAL))
			port_old <= stable[6:3];
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			port_dir <= PORT_DIR_RESET;
		else if (wr_go && isp_hit(paddr, OFF_PORT_DIR))
			port_dir <= wb[7:4];
	end

	// Reset control: hardware set wins over clear and over software
	always_ff @(posedge core_clk)
	begin
		if (srst)
			reset_control_reg <= RC_RESET;
		else
		begin
			if (wr_go && isp_hit(paddr, OFF_RESET_CTRL))
				reset_control_reg <= ((reset_control_reg & ~RC_WR_MASK & ~{3'h0, cause_clr})
					| (wb & RC_WR_MASK) | {3'h0, cause_set}) & RC_IMPL_MASK;
			else
				reset_control_reg <= ((reset_control_reg & ~{3'h0, cause_clr})
					| {3'h0, cause_set}) & RC_IMPL_MASK;
		end
	end

	// Interrupt control: flags set by events, set wins over a written clear
	always_ff @(posedge core_clk)
	begin
		if (srst)
			irq_control_reg <= IC_RESET;
		else
		begin
			irq_control_reg <= (wr_go && isp_hit(paddr, OFF_IRQ_CTRL)) ? wb : irq_control_reg;
			if (ext_edge[0])
				irq_control_reg[IC_EXT0_FLAG] <= 1'b1;
			if (tmr_ovf)
				irq_control_reg[IC_TMR_FLAG] <= 1'b1;
			if (|port_mis)
				irq_control_reg[IC_PORT_FLAG] <= 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			irq_control_reg_second <= IC2_RESET;
		else if (wr_go && isp_hit(paddr, OFF_IRQ_CTRL2))
			irq_control_reg_second <= wb & IC2_MASK;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			irq_control_reg_third <= IC3_RESET;
		else
		begin
			if (wr_go && isp_hit(paddr, OFF_IRQ_CTRL3))
				irq_control_reg_third <= wb & IC3_MASK;
			if (ext_edge[1])
				irq_control_reg_third[IC3_EXT1_FLAG] <= 1'b1;
			if (ext_edge[2])
				irq_control_reg_third[IC3_EXT2_FLAG] <= 1'b1;
		end
	end

	// Timer zero count; a software write takes precedence over a tick
	assign tmr_inc = timer_tick && tmr_cfg[TCFG_RUN];
	assign wrap_low = tmr_inc && (tmr_low == 8'hFF);
	assign tmr_ovf = tmr_cfg[TCFG_WIDE] ? (wrap_low && tmr_high == 8'hFF) : wrap_low;

	always_ff @(posedge core_clk)
	begin
		if (srst)
			tmr_cfg <= TCFG_RESET;
		else if (wr_go && isp_hit(paddr, OFF_TMR_CFG))
			tmr_cfg <= wb & TCFG_MASK;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			tmr_low <= 8'h00;
		else if (wr_go && isp_hit(paddr, OFF_TMR_LOW))
			tmr_low <= wb;
		else if (tmr_inc)
			tmr_low <= tmr_low + 8'h01;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			tmr_high <= 8'h00;
		else if (wr_go && isp_hit(paddr, OFF_TMR_HIGH))
			tmr_high <= wb;
		else if (wrap_low && tmr_cfg[TCFG_WIDE])
			tmr_high <= tmr_high + 8'h01;
	end

	// Priority resolution
	assign src_flag = {irq_control_reg[IC_PORT_FLAG], irq_control_reg[IC_TMR_FLAG],
		irq_control_reg_third[IC3_EXT2_FLAG], irq_control_reg_third[IC3_EXT1_FLAG],
		irq_control_reg[IC_EXT0_FLAG]};
	assign src_en = {irq_control_reg[IC_PORT_EN], irq_control_reg[IC_TMR_EN],
		irq_control_reg_third[IC3_EXT2_EN], irq_control_reg_third[IC3_EXT1_EN],
		irq_control_reg[IC_EXT0_EN]};
	assign src_prio = {irq_control_reg_second[IC2_PORT_PRIO],
		irq_control_reg_second[IC2_TMR_PRIO],
		irq_control_reg_third[IC3_EXT2_PRIO], irq_control_reg_third[IC3_EXT1_PRIO],
		1'b1};
	assign src_active = src_flag & src_en;

	always_comb
	begin
		if (priority_levels_enable)
		begin
			next_high = irq_control_reg[IC_GLOBAL_EN] && |(src_active & src_prio);
			next_low = irq_control_reg[IC_LOW_EN] && |(src_active & ~src_prio) && !next_high;
		end
		else
		begin
			next_high = irq_control_reg[IC_GLOBAL_EN] && |src_active;
			next_low = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			irq_high <= 1'b0;
			irq_low <= 1'b0;
			wake_req <= 1'b0;
			wake_branch <= 1'b0;
		end
		else
		begin
			irq_high <= next_high;
			irq_low <= next_low;
			wake_req <= core_sleep && |src_active;
			wake_branch <= core_sleep && (next_high || next_low);
		end
	end

	// Context saving on entry
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			fast_working_reg <= 8'h00;
			fast_status_reg <= 8'h00;
			fast_bank_select_reg <= 8'h00;
		end
		else if (core_irq_ack)
		begin
			fast_working_reg <= core_working_reg;
			fast_status_reg <= core_status_reg;
			fast_bank_select_reg <= core_bank_select_reg;
		end
	end

	assign push = core_irq_ack && (stk_ptr < STK_DEPTH);
	assign pop = !core_irq_ack && core_irq_return && (stk_ptr != 6'h00);

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			stk_ptr <= 6'h00;
			stk_ovf <= 1'b0;
			stk_unf <= 1'b0;
			ret_pc_valid <= 1'b0;
		end
		else
		begin
			ret_pc_valid <= pop;
			if (push)
				stk_ptr <= stk_ptr + 6'h01;
			else if (pop)
				stk_ptr <= stk_ptr - 6'h01;
			if (core_irq_ack && !push)
				stk_ovf <= 1'b1;
			else if (wr_go && isp_hit(paddr, OFF_CORE_STAT) && wb[CS_OVF])
				stk_ovf <= 1'b0;
			if (!core_irq_ack && core_irq_return && stk_ptr == 6'h00)
				stk_unf <= 1'b1;
			else if (wr_go && isp_hit(paddr, OFF_CORE_STAT) && wb[CS_UNF])
				stk_unf <= 1'b0;
		end
	end

	isp_stack_mem u_stack (
		.core_clk (core_clk),
		.we       (push),
		.waddr    (stk_ptr[STK_AW-1:0]),
		.wdata    (core_ret_pc),
		.re       (pop),
		.raddr    (stk_ptr[STK_AW-1:0] - 5'h01),
		.rdata    (ret_pc)
	);

	unimpl_zero_a: assert property (@(posedge core_clk) disable iff (srst)
		(psel && penable && !pwrite && paddr == OFF_RESET_CTRL) |-> prdata[6:5] == 2'b00)
		else $error("reset control bits 6:5 not zero");
	prio_write_a: assert property (@(posedge core_clk) disable iff (srst)
		(wr_go && paddr == OFF_RESET_CTRL) |=> reset_control_reg[RC_PRIO_EN] == $past(wb[7]))
		else $error("priority enable not written");
	single_level_a: assert property (@(posedge core_clk) disable iff (srst)
		!priority_levels_enable |=> !irq_low)
		else $error("low request with priority levels off");
	edge_flag_a: assert property (@(posedge core_clk) disable iff (srst)
		(changed[0] && sync3[0] == ext_edge_select[0]) |=> irq_control_reg[IC_EXT0_FLAG])
		else $error("edge did not set flag");
	gated_off_a: assert property (@(posedge core_clk) disable iff (srst)
		(src_active == 5'h00) |=> !irq_high && !irq_low && !wake_req)
		else $error("request without enabled flag");
	ext0_high_a: assert property (@(posedge core_clk) disable iff (srst)
		(priority_levels_enable && irq_control_reg[IC_GLOBAL_EN] && src_active[0])
		|=> irq_high && !irq_low)
		else $error("external zero not high priority");
	wrap8_a: assert property (@(posedge core_clk) disable iff (srst)
		(tmr_inc && !tmr_cfg[TCFG_WIDE] && tmr_low == 8'hFF) |=> irq_control_reg[IC_TMR_FLAG])
		else $error("8-bit wrap missed");
	wrap16_a: assert property (@(posedge core_clk) disable iff (srst)
		(tmr_inc && tmr_cfg[TCFG_WIDE] && tmr_low == 8'hFF && tmr_high != 8'hFF
		&& !irq_control_reg[IC_TMR_FLAG] && !wr_go) |=> !irq_control_reg[IC_TMR_FLAG])
		else $error("16-bit mode flagged low wrap");
	out_pin_a: assert property (@(posedge core_clk) disable iff (srst)
		(port_dir == 4'h0 && !irq_control_reg[IC_PORT_FLAG] && !wr_go)
		|=> !irq_control_reg[IC_PORT_FLAG])
		else $error("output pin raised port change");
	wake_a: assert property (@(posedge core_clk) disable iff (srst)
		(core_sleep && src_active != 5'h00) |=> wake_req)
		else $error("no wake from enabled flag");
	fast_save_a: assert property (@(posedge core_clk) disable iff (srst)
		core_irq_ack |=> fast_working_reg == $past(core_working_reg)
		&& fast_bank_select_reg == $past(core_bank_select_reg))
		else $error("context not saved");

	ext_flag_c: cover property (@(posedge core_clk) disable iff (srst) ext_edge[1] ##1 irq_high);
	wrap16_c: cover property (@(posedge core_clk) disable iff (srst)
		tmr_ovf && tmr_cfg[TCFG_WIDE]);
	low_irq_c: cover property (@(posedge core_clk) disable iff (srst) irq_low);
	stack_c: cover property (@(posedge core_clk) disable iff (srst) push ##[1:20] pop);
endmodule

/* isp_irq_sources_tb.sv */
// Bench for the interrupt source block: APB master, pin drivers, core model.
// Assumes isp_pkg and isp_core_model are compiled first.
`timescale 1ns/1ps
module isp_irq_sources_tb
	import isp_pkg::*;
;
	localparam logic [PC_W-1:0] EPC = 21'h0ABCD;
	localparam logic [23:0]     CTX = 24'hA53C0F;
	logic              core_clk = 1'b0, srst = 1'b1, pready, pslverr, rd_err;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rd_data;
	logic [N_EXT-1:0]  ext_irq_pins = '0;
	logic [N_PORT-1:0] port_pins = '0;
	logic              timer_tick = 1'b0, core_sleep = 1'b0, ack_en = 1'b0, ret_req = 1'b0;
	logic [4:0]        cause_set = '0, cause_clr = '0;
	logic [3:0]        pstrb = 4'hF;
	logic              core_irq_ack, core_irq_return, irq_high, irq_low;
	logic              wake_req, wake_branch, ret_pc_valid;
	logic [PC_W-1:0]   core_ret_pc, ret_pc;
	logic [7:0]        core_working_reg, core_status_reg, core_bank_select_reg;
	logic [7:0]        fast_working_reg, fast_status_reg, fast_bank_select_reg;
	int                bad_count = 0, samples_checked = 0;

	always #5 core_clk = ~core_clk;

	isp_irq_sources u_dut (
		.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .ext_irq_pins, .port_pins, .timer_tick,
		.cause_set, .cause_clr, .core_sleep, .core_irq_ack, .core_irq_return,
		.core_ret_pc, .core_working_reg, .core_status_reg, .core_bank_select_reg,
		.irq_high, .irq_low, .wake_req, .wake_branch, .ret_pc, .ret_pc_valid,
		.fast_working_reg, .fast_status_reg, .fast_bank_select_reg
	);
	isp_core_model #(.ENTRY_PC(EPC), .CTX(CTX)) u_core (
		.core_clk, .srst, .irq_high, .irq_low, .ack_en, .ret_req, .core_irq_ack,
		.core_irq_return, .core_ret_pc, .core_working_reg, .core_status_reg,
		.core_bank_select_reg
	);

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			chk("pready", 32'h1, {31'h0, pready});
			report_and_stop();
		end
		rd_data = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	// Reads until the masked byte matches or eight reads have gone by
	task automatic rdp(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, a, 8'h00);
			n++;
		end
		while ((rd_data[7:0] & m) !== e && n < 8);
		chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, rd_data[7:0] & m});
	endtask

	task automatic po(input logic [3:0] e);
		int n;
		n = 0;
		while ({wake_branch, wake_req, irq_low, irq_high} !== e && n < 8)
		begin
			@(posedge core_clk);
			n++;
		end
		chk("requests", {28'h0, e}, {28'h0, wake_branch, wake_req, irq_low, irq_high});
	endtask

	task automatic pins(input logic [2:0] x, input logic [3:0] p);
		@(posedge core_clk);
		ext_irq_pins <= x;
		port_pins    <= p;
	endtask

	task automatic tick();
		@(posedge core_clk);
		timer_tick <= 1'b1;
		@(posedge core_clk);
		timer_tick <= 1'b0;
	endtask

	task automatic t_regs();
		rdp(OFF_RESET_CTRL, 8'hFF, RC_RESET);
		rdp(OFF_IRQ_CTRL3, 8'hFF, IC3_RESET);
		wr(OFF_RESET_CTRL, 8'hFF);
		rdp(OFF_RESET_CTRL, 8'hFF, 8'h9F);
		wr(OFF_RESET_CTRL, 8'h00);
		rdp(OFF_RESET_CTRL, 8'hFF, 8'h0C);
		pstrb <= 4'h0;
		wr(OFF_RESET_CTRL, 8'h80);
		pstrb <= 4'hF;
		rdp(OFF_RESET_CTRL, 8'hFF, 8'h0C);
		@(posedge core_clk);
		cause_set <= 5'h03;
		cause_clr <= 5'h0D;
		@(posedge core_clk);
		cause_set <= 5'h00;
		cause_clr <= 5'h00;
		rdp(OFF_RESET_CTRL, 8'hFF, 8'h03);
		apb(1'b0, 8'h3C, 8'h00);
		chk("unmapped error", 32'h1, {31'h0, rd_err});
		chk("unmapped data", 32'h0, rd_data);
	endtask

	task automatic t_edges();
		for (int e = 0; e < 2; e++)
		begin
			wr(OFF_IRQ_CTRL2, e ? 8'h75 : 8'h05);
			pins(e ? 3'b000 : 3'b111, 4'h0);
			repeat (8) @(posedge core_clk);
			wr(OFF_IRQ_CTRL, 8'h00);
			wr(OFF_IRQ_CTRL3, 8'hC0);
			pins(e ? 3'b111 : 3'b000, 4'h0);
			rdp(OFF_IRQ_CTRL, 8'h02, 8'h02);
			rdp(OFF_IRQ_CTRL3, 8'h03, 8'h03);
			wr(OFF_IRQ_CTRL, 8'h00);
			wr(OFF_IRQ_CTRL3, 8'hC0);
			pins(e ? 3'b000 : 3'b111, 4'h0);
			repeat (8) @(posedge core_clk);
			rdp(OFF_IRQ_CTRL, 8'h02, 8'h00);
			rdp(OFF_IRQ_CTRL3, 8'h03, 8'h00);
		end
	endtask

	task automatic t_prio();
		pins(3'b010, 4'h0);
		rdp(OFF_IRQ_CTRL3, 8'h01, 8'h01);
		wr(OFF_IRQ_CTRL, 8'hC0);
		po(4'b0000);
		wr(OFF_RESET_CTRL, 8'h80);
		wr(OFF_IRQ_CTRL3, 8'h09);
		po(4'b0010);
		wr(OFF_IRQ_CTRL3, 8'h49);
		po(4'b0001);
		wr(OFF_IRQ_CTRL3, 8'h09);
		wr(OFF_RESET_CTRL, 8'h00);
		po(4'b0001);
		wr(OFF_RESET_CTRL, 8'h80);
		wr(OFF_IRQ_CTRL3, 8'h00);
		wr(OFF_IRQ_CTRL, 8'h90);
		pins(3'b011, 4'h0);
		po(4'b0001);
		@(posedge core_clk);
		core_sleep <= 1'b1;
		wr(OFF_IRQ_CTRL, 8'h12);
		po(4'b0100);
		wr(OFF_IRQ_CTRL, 8'h92);
		po(4'b1101);
		rdp(OFF_CORE_STAT, 8'h13, 8'h11);
		core_sleep <= 1'b0;
		wr(OFF_IRQ_CTRL, 8'h00);
	endtask

	task automatic t_timer();
		wr(OFF_TMR_LOW, 8'hFF);
		wr(OFF_TMR_CFG, 8'h02);
		tick();
		rdp(OFF_IRQ_CTRL, 8'h04, 8'h04);
		wr(OFF_IRQ_CTRL, 8'hA4);
		po(4'b0001);
		wr(OFF_IRQ_CTRL2, 8'h71);
		wr(OFF_IRQ_CTRL, 8'hE4);
		po(4'b0010);
		wr(OFF_IRQ_CTRL, 8'h00);
		wr(OFF_TMR_LOW, 8'hFF);
		wr(OFF_TMR_CFG, 8'h03);
		tick();
		repeat (4) @(posedge core_clk);
		rdp(OFF_IRQ_CTRL, 8'h04, 8'h00);
		wr(OFF_TMR_LOW, 8'hFF);
		wr(OFF_TMR_HIGH, 8'hFF);
		tick();
		rdp(OFF_IRQ_CTRL, 8'h04, 8'h04);
		wr(OFF_TMR_CFG, 8'h00);
		wr(OFF_IRQ_CTRL, 8'h00);
	endtask

	task automatic t_port();
		wr(OFF_PORT_DIR, 8'h70);
		rdp(OFF_PORT_VAL, 8'hF0, 8'h00);
		wr(OFF_IRQ_CTRL, 8'h00);
		pins(3'b011, 4'h8);
		repeat (8) @(posedge core_clk);
		rdp(OFF_IRQ_CTRL, 8'h01, 8'h00);
		pins(3'b011, 4'h9);
		rdp(OFF_IRQ_CTRL, 8'h01, 8'h01);
		wr(OFF_IRQ_CTRL, 8'h89);
		po(4'b0001);
		rdp(OFF_PORT_VAL, 8'hF0, 8'h90);
		wr(OFF_IRQ_CTRL, 8'h00);
		repeat (4) @(posedge core_clk);
		rdp(OFF_IRQ_CTRL, 8'h01, 8'h00);
		wr(OFF_PORT_DIR, 8'h00);
		pins(3'b011, 4'h6);
		repeat (8) @(posedge core_clk);
		rdp(OFF_IRQ_CTRL, 8'h01, 8'h00);
	endtask

	task automatic t_ctx();
		int n;
		@(posedge core_clk);
		ack_en <= 1'b1;
		wr(OFF_IRQ_CTRL, 8'h92);
		n = 0;
		while (fast_working_reg !== CTX[23:16] && n < 20)
		begin
			@(posedge core_clk);
			n++;
		end
		chk("fast copy", {8'h0, CTX}, {8'h0, fast_working_reg, fast_status_reg,
			fast_bank_select_reg});
		ack_en <= 1'b0;
		wr(OFF_IRQ_CTRL, 8'h00);
		@(posedge core_clk);
		ret_req <= 1'b1;
		@(posedge core_clk);
		ret_req <= 1'b0;
		n = 0;
		while (ret_pc_valid !== 1'b1 && n < 8)
		begin
			@(posedge core_clk);
			n++;
		end
		chk("return pc", {11'h0, EPC}, {11'h0, ret_pc});
	endtask

	initial
	begin
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		t_regs();
		t_edges();
		t_prio();
		t_timer();
		t_port();
		t_ctx();
		report_and_stop();
	end
endmodule

/* isp_pkg.sv */
// Constants for the interrupt source block: register offsets, field positions,
// reset values and sizes. Assumes a 32-bit APB with byte addresses on paddr.
package isp_pkg;
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 32;
	localparam logic [7:0]  OFF_RESET_CTRL = 8'h00;
	localparam logic [7:0]  OFF_IRQ_CTRL   = 8'h04;
	localparam logic [7:0]  OFF_IRQ_CTRL2  = 8'h08;
	localparam logic [7:0]  OFF_IRQ_CTRL3  = 8'h0C;
	localparam logic [7:0]  OFF_TMR_LOW    = 8'h10;
	localparam logic [7:0]  OFF_TMR_HIGH   = 8'h14;
	localparam logic [7:0]  OFF_TMR_CFG    = 8'h18;
	localparam logic [7:0]  OFF_PORT_VAL   = 8'h1C;
	localparam logic [7:0]  OFF_PORT_DIR   = 8'h20;
	localparam logic [7:0]  OFF_CORE_STAT  = 8'h24;
	localparam int          RC_PRIO_EN     = 7;
	localparam int          RC_SW_RESET    = 4;
	localparam int          RC_WDOG        = 3;
	localparam int          RC_PDOWN       = 2;
	localparam int          RC_POWERON     = 1;
	localparam int          RC_BROWNOUT    = 0;
	localparam logic [7:0]  RC_RESET       = 8'h1C;
	localparam logic [7:0]  RC_WR_MASK     = 8'h93;
	localparam logic [7:0]  RC_IMPL_MASK   = 8'h9F;
	localparam int          IC_GLOBAL_EN   = 7;
	localparam int          IC_LOW_EN      = 6;
	localparam int          IC_TMR_EN      = 5;
	localparam int          IC_EXT0_EN     = 4;
	localparam int          IC_PORT_EN     = 3;
	localparam int          IC_TMR_FLAG    = 2;
	localparam int          IC_EXT0_FLAG   = 1;
	localparam int          IC_PORT_FLAG   = 0;
	localparam logic [7:0]  IC_RESET       = 8'h00;
	localparam int          IC2_EDGE0      = 6;
	localparam int          IC2_EDGE1      = 5;
	localparam int          IC2_EDGE2      = 4;
	localparam int          IC2_TMR_PRIO   = 2;
	localparam int          IC2_PORT_PRIO  = 0;
	localparam logic [7:0]  IC2_RESET      = 8'h75;
	localparam logic [7:0]  IC2_MASK       = 8'h75;
	localparam int          IC3_EXT2_PRIO  = 7;
	localparam int          IC3_EXT1_PRIO  = 6;
	localparam int          IC3_EXT2_EN    = 4;
	localparam int          IC3_EXT1_EN    = 3;
	localparam int          IC3_EXT2_FLAG  = 1;
	localparam int          IC3_EXT1_FLAG  = 0;
	localparam logic [7:0]  IC3_RESET      = 8'hC0;
	localparam logic [7:0]  IC3_MASK       = 8'hDB;
	localparam int          TCFG_WIDE      = 0;
	localparam int          TCFG_RUN       = 1;
	localparam logic [7:0]  TCFG_RESET     = 8'h00;
	localparam logic [7:0]  TCFG_MASK      = 8'h03;
	localparam logic [3:0]  PORT_DIR_RESET = 4'hF;
	localparam int          CS_HIGH        = 0;
	localparam int          CS_LOW         = 1;
	localparam int          CS_OVF         = 2;
	localparam int          CS_UNF         = 3;
	localparam int          CS_WAKE        = 4;
	localparam int          N_EXT          = 3;
	localparam int          N_PORT         = 4;
	localparam int          N_SRC          = 5;
	localparam int          PC_W           = 21;
	localparam int          STK_AW         = 5;
	localparam logic [5:0]  STK_DEPTH      = 6'h1F;
endpackage

/* isp_stack_mem.sv */
// Return address stack storage: one write port, one read port.
// Assumes the caller keeps the pointer; read data appear one clock after re.
`timescale 1ns/1ps
module isp_stack_mem
	import isp_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              we,
	input  wire logic [STK_AW-1:0] waddr,
	input  wire logic [PC_W-1:0]   wdata,
	input  wire logic              re,
	input  wire logic [STK_AW-1:0] raddr,
	output logic      [PC_W-1:0]   rdata
);
	logic [PC_W-1:0] mem [0:(1<<STK_AW)-1];

	always_ff @(posedge core_clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (re)
			rdata <= mem[raddr];
	end
endmodule
